// >>> hdl/mrf_pkg.sv
// mrf_pkg: constants and types shared by the receive filter design.
// assumes a single 25 MHz system clock domain; no bus, plain ports only.
package mrf_pkg;
    // ------------------------------------------------------------
    // mode and control word field positions
    // ------------------------------------------------------------
    localparam int unsigned MODE_UNICAST_REJECT_BIT = 13;
    localparam int unsigned MODE_BROADCAST_REJECT_BIT = 14;
    localparam int unsigned MODE_PROMISCUOUS_BIT = 15;
    localparam int unsigned CTRL_PAD_STRIP_BIT = 0;
    // ------------------------------------------------------------
    // frame figures
    // ------------------------------------------------------------
    localparam logic [10:0] MIN_FRAME_BYTES = 11'h040;
    localparam logic [10:0] COLL_WINDOW_BITS = 11'h200;
    localparam logic [15:0] PAD_LENGTH_LIMIT = 16'h002e;
    localparam logic [10:0] HDR_BYTES = 11'h00e;
    localparam logic [10:0] FCS_BYTES = 11'h004;
    // the crc register shifts lsb first, so the good-frame residue is the bit-reversed form
    localparam logic [31:0] FCS_RESIDUE = 32'hdebb20e3;
    // ------------------------------------------------------------
    // watermark encoding, reset value 10b = 64 bytes
    // ------------------------------------------------------------
    localparam logic [1:0] WATERMARK_RESET = 2'h2;
    localparam logic [7:0] WM_BYTES_0 = 8'h10;
    localparam logic [7:0] WM_BYTES_1 = 8'h20;
    localparam logic [7:0] WM_BYTES_2 = 8'h40;
    localparam logic [7:0] WM_BYTES_3 = 8'h70;
    localparam int unsigned BUF_DEPTH = 2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_DROP = 2'b11,
        ST_DONE = 2'b10
    } mrf_state_t;
endpackage

// >>> hdl/mrf_rx_filter.sv
// mrf_rx_filter: receive address filter, pad strip, fcs check, runt/collision drop.
// assumes the decoder bit stream is asynchronous to mclk and is sampled through
// two flip-flops; each decoder bit stays stable at least three mclk cycles.
//
// Notes on behaviour
// - first destination bit zero means unicast, else multicast
// - all-ones destination is broadcast, handled apart
// - unicast kept only on full station match
// - byte n compared with station bits [8n+7:8n]
// - unicast_reject drops all unicast frames
// - multicast decided by hash filter; zero rejects
// - broadcast kept unless broadcast_reject set
// - promiscuous accepts every address, overriding both rejects
// - promiscuous still drops runt frames
// - watermark flag tells buffer manager to move data
// - pad_strip_enable removes pad before fifo
// - stripping pad also removes the four fcs bytes
// - strip only when length field below 46
// - keep length-field data bytes, drop rest
// - fcs checked over every received byte including pad
// - fcs mismatch sets descriptor fcs error flag
// - collision in first 512 bits deletes frame
// - frames under 64 bytes dropped unless runt_accept
// - deletion works with earlier frame still queued
`timescale 1ns/1ps
`default_nettype none
module mrf_rx_filter
(
    input wire logic mclk,
    input wire logic rst_n,
    // decoder bit stream
    input wire logic dec_active,
    input wire logic dec_bit,
    input wire logic dec_bit_strobe,
    input wire logic dec_collision,
    // configuration
    input wire logic [15:0] mode_word,
    input wire logic [15:0] ctrl_word,
    input wire logic [47:0] station_address,
    input wire logic [63:0] multicast_hash_filter,
    input wire logic hash_hit,
    input wire logic runt_accept,
    input wire logic [1:0] rx_fifo_watermark,
    // receive fifo side
    output logic fifo_valid,
    input wire logic fifo_ready,
    output logic [7:0] fifo_data,
    output logic fifo_commit,
    output logic fifo_discard,
    input wire logic [7:0] fifo_level,
    // descriptor status and buffer manager
    output logic status_valid,
    output logic fcs_error_flag,
    output logic [10:0] status_length,
    output logic buffer_manager_start
);
    typedef struct packed {
        logic [2:0] sa;
        logic [2:0] sb;
        logic [2:0] sc;
        logic [2:0] ss;
        mrf_pkg::mrf_state_t st;
        logic [7:0] shift;
        logic [2:0] bitc;
        logic [10:0] bitn;
        logic [10:0] bytes;
        logic [31:0] crc;
        logic [47:0] dest;
        logic [15:0] lenf;
        logic [10:0] keep;
        logic strip;
        logic coll;
        logic [1:0] cnt;
        logic [1:0][7:0] buf_d;
        logic ov;
        logic cm;
        logic dc;
        logic sv;
        logic fe;
        logic [10:0] sl;
        logic bm;
    } mrf_s_t;
    mrf_s_t s_reg;
    mrf_s_t s_next;
    logic bit_pulse;
    logic byte_done;
    logic [7:0] nbyte;
    logic [31:0] crc_n;
    logic accept;
    logic is_mc;
    logic is_bc;
    logic keep_byte;
    logic ended;
    logic push;
    logic [7:0] wm;
    logic dec_collision_s;
    logic [1:0] coll_sync;
    // ------------------------------------------------------------
    // collision synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            coll_sync <= 2'h0;
        else
            coll_sync <= {coll_sync[0], dec_collision};
    end
    assign dec_collision_s = coll_sync[1];
    // ------------------------------------------------------------
    // classification and address decision
    // ------------------------------------------------------------
    always_comb
    begin
        is_mc = s_reg.dest[0];
        is_bc = &s_reg.dest;
        if (mode_word[mrf_pkg::MODE_PROMISCUOUS_BIT])
            accept = 1'b1;
        else if (is_bc)
            accept = !mode_word[mrf_pkg::MODE_BROADCAST_REJECT_BIT];
        else if (is_mc)
            accept = hash_hit && (|multicast_hash_filter);
        else
            accept = !mode_word[mrf_pkg::MODE_UNICAST_REJECT_BIT] &&
                (s_reg.dest == station_address);
        unique case (rx_fifo_watermark)
            2'h0: wm = mrf_pkg::WM_BYTES_0;
            2'h1: wm = mrf_pkg::WM_BYTES_1;
            2'h2: wm = mrf_pkg::WM_BYTES_2;
            2'h3: wm = mrf_pkg::WM_BYTES_3;
        endcase
    end
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.sa = {dec_active, dec_bit, dec_bit_strobe};
        s_next.sb = s_reg.sa;
        s_next.sc = s_reg.sb;
        s_next.cm = 1'b0;
        s_next.dc = 1'b0;
        s_next.sv = 1'b0;
        bit_pulse = s_reg.sb[0] && !s_reg.sc[0] && s_reg.sb[2];
        nbyte = {s_reg.sb[1], s_reg.shift[7:1]};
        byte_done = bit_pulse && (s_reg.bitc == 3'h7);
        crc_n = s_reg.crc;
        // bitwise crc over every bit, pad included, residue checked at end
        if (s_reg.sb[1] ^ s_reg.crc[0])
            crc_n = {1'b0, s_reg.crc[31:1]} ^ 32'hedb88320;
        else
            crc_n = {1'b0, s_reg.crc[31:1]};
        ended = !s_reg.sb[2] && s_reg.sc[2];
        keep_byte = !s_reg.strip || (s_reg.bytes < mrf_pkg::HDR_BYTES) ||
            (s_reg.bytes < s_reg.keep);
        push = 1'b0;
        if (s_reg.sb[2] && s_reg.ss[2] == 1'b0 && s_reg.bitn == 11'h000 &&
            s_reg.st == mrf_pkg::ST_IDLE)
            s_next.crc = 32'hffffffff;
        unique case (s_reg.st)
            mrf_pkg::ST_IDLE:
            begin
                s_next.bitc = 3'h0;
                s_next.bitn = 11'h000;
                s_next.bytes = 11'h000;
                s_next.strip = 1'b0;
                s_next.coll = 1'b0;
                s_next.crc = 32'hffffffff;
                if (s_reg.sb[2])
                    s_next.st = mrf_pkg::ST_RECV;
            end
            mrf_pkg::ST_RECV:
            begin
                if (bit_pulse)
                begin
                    s_next.shift = nbyte;
                    s_next.bitc = s_reg.bitc + 3'h1;
                    s_next.crc = crc_n;
                    if (s_reg.bitn < mrf_pkg::COLL_WINDOW_BITS)
                        s_next.bitn = s_reg.bitn + 11'h001;
                end
                if (dec_collision_s && s_reg.bitn < mrf_pkg::COLL_WINDOW_BITS)
                    s_next.coll = 1'b1;
                if (byte_done)
                begin
                    s_next.bytes = s_reg.bytes + 11'h001;
                    for (int i = 0; i < 6; i++)
                        if (s_reg.bytes == 11'(i))
                            s_next.dest[i*8 +: 8] = nbyte;
                    if (s_reg.bytes == 11'h00c)
                        s_next.lenf[15:8] = nbyte;
                    if (s_reg.bytes == 11'h00d)
                    begin
                        s_next.lenf[7:0] = nbyte;
                        if (ctrl_word[mrf_pkg::CTRL_PAD_STRIP_BIT] &&
                            {s_reg.lenf[15:8], nbyte} < mrf_pkg::PAD_LENGTH_LIMIT)
                        begin
                            s_next.strip = 1'b1;
                            s_next.keep = mrf_pkg::HDR_BYTES + 11'({s_reg.lenf[15:8], nbyte});
                        end
                    end
                    if (s_reg.bytes == 11'h006 && !accept)
                    begin
                        s_next.st = mrf_pkg::ST_DROP;
                        s_next.coll = 1'b1;
                    end
                    else if (keep_byte)
                        push = 1'b1;
                end
                if (ended)
                begin
                    s_next.st = mrf_pkg::ST_DONE;
                end
            end
            mrf_pkg::ST_DROP:
            begin
                // the first six bytes are already written, so the drop ends in a discard
                if (ended)
                    s_next.st = mrf_pkg::ST_DONE;
            end
            mrf_pkg::ST_DONE:
            begin
                // runt and collision drop whatever was written, queued frames untouched
                if (s_reg.cnt == 2'h0)
                begin
                    if (s_reg.coll || (!runt_accept &&
                        s_reg.bytes < mrf_pkg::MIN_FRAME_BYTES))
                        s_next.dc = 1'b1;
                    else
                    begin
                        s_next.cm = 1'b1;
                        s_next.sv = 1'b1;
                        s_next.fe = s_reg.crc != mrf_pkg::FCS_RESIDUE;
                        s_next.sl = s_reg.strip ? s_reg.keep : s_reg.bytes;
                    end
                    s_next.st = mrf_pkg::ST_IDLE;
                end
            end
        endcase
        s_next.ss = s_reg.sb;
        // two-entry skid buffer in front of the fifo write port
        if (fifo_valid && fifo_ready)
        begin
            s_next.buf_d[0] = s_reg.buf_d[1];
            s_next.cnt = s_reg.cnt - 2'h1;
        end
        if (push && s_next.cnt != 2'(mrf_pkg::BUF_DEPTH))
        begin
            s_next.buf_d[s_next.cnt[0]] = nbyte;
            s_next.cnt = s_next.cnt + 2'h1;
        end
        s_next.ov = s_next.cnt != 2'h0;
        s_next.bm = fifo_level >= wm;
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.crc <= 32'hffffffff;
        end
        else
            s_reg <= s_next;
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign fifo_valid = s_reg.ov;
    assign fifo_data = s_reg.buf_d[0];
    assign fifo_commit = s_reg.cm;
    assign fifo_discard = s_reg.dc;
    assign status_valid = s_reg.sv;
    assign fcs_error_flag = s_reg.fe;
    assign status_length = s_reg.sl;
    assign buffer_manager_start = s_reg.bm;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    drop_no_status_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fifo_discard |-> !status_valid) else $error("discard with status");
    runt_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        status_valid && !runt_accept |-> $past(s_reg.bytes) >= mrf_pkg::MIN_FRAME_BYTES)
        else $error("runt frame kept");
    wm_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 buffer_manager_start == ($past(fifo_level) >= $past(wm)))
        else $error("watermark flag wrong");
    buf_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fifo_valid && !fifo_ready && s_reg.cnt == 2'h2 |=> fifo_valid &&
        $stable(fifo_data)) else $error("buffer lost word");
    bc_reject_a: assert property (@(posedge mclk) disable iff (!rst_n)
        status_valid && mode_word[mrf_pkg::MODE_BROADCAST_REJECT_BIT] &&
        !mode_word[mrf_pkg::MODE_PROMISCUOUS_BIT] |-> !is_bc) else $error("broadcast kept");
    uc_reject_a: assert property (@(posedge mclk) disable iff (!rst_n)
        status_valid && mode_word[mrf_pkg::MODE_UNICAST_REJECT_BIT] &&
        !mode_word[mrf_pkg::MODE_PROMISCUOUS_BIT] |-> is_mc) else $error("unicast kept");
    coll_commit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fifo_commit |-> !s_reg.coll)
        else $error("deleted frame committed");
    commit_excl_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(fifo_commit && fifo_discard))
        else $error("commit with discard");
endmodule
`default_nettype wire

// >>> test/mrf_dec_model.sv
// mrf_dec_model: decoder side, plays a byte array as an lsb-first bit stream.
// assumes mclk at 25 MHz; the bench fills fr[] and calls send.
`timescale 1ns/1ps
`default_nettype none
module mrf_dec_model
(
    // clock
    input wire logic mclk,
    // decoder stream
    output logic dec_active,
    output logic dec_bit,
    output logic dec_bit_strobe,
    output logic dec_collision
);
    logic [7:0] fr [0:127];
    initial
    begin
        dec_active = 1'b0;
        dec_bit = 1'b0;
        dec_bit_strobe = 1'b0;
        dec_collision = 1'b0;
    end
    // strobe high three cycles, low three: the shortest the design assumes
    task automatic send(input int n, input int coll);
        int i;
        int b;
        @(negedge mclk);
        dec_active = 1'b1;
        for (i = 0; i < n; i++)
        begin
            if (i == coll)
                dec_collision = 1'b1;
            for (b = 0; b < 8; b++)
            begin
                @(negedge mclk);
                dec_bit = fr[i][b];
                dec_bit_strobe = 1'b1;
                repeat (3) @(negedge mclk);
                dec_bit_strobe = 1'b0;
                repeat (2) @(negedge mclk);
            end
        end
        @(negedge mclk);
        dec_active = 1'b0;
        dec_collision = 1'b0;
        // released line shows the inverse so a stale bit cannot pass
        dec_bit = ~dec_bit;
        repeat (3) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> test/mrf_rx_filter_tb.sv
// mrf_rx_filter_tb: frame scenarios for the receive filter.
// assumes the decoder model and a fifo sink stalling one cycle in four.
`timescale 1ns/1ps
`default_nettype none
module mrf_rx_filter_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic act, bitv, stb, coll, hash_hit = 1'b0, runt_accept = 1'b0, fifo_ready = 1'b0;
    logic [15:0] mode_word = 16'h0000, ctrl_word = 16'h0000;
    logic [47:0] sta = 48'h5a4433221100;
    logic [63:0] hf = 64'h0;
    logic [1:0] wm = mrf_pkg::WATERMARK_RESET;
    logic [7:0] level = 8'h00, fifo_data;
    logic fifo_valid, fifo_commit, fifo_discard, status_valid, fcs_err, bms;
    logic [10:0] status_length;
    logic [1:0] rc = 2'h0;
    int num_errors = 0, tests_run = 0, pushes, gc, gd, gs, gl;
    mrf_dec_model u_mrf_dec_model (.mclk(mclk), .dec_active(act), .dec_bit(bitv),
        .dec_bit_strobe(stb), .dec_collision(coll));
    mrf_rx_filter u_mrf_rx_filter (.mclk(mclk), .rst_n(rst_n), .dec_active(act),
        .dec_bit(bitv), .dec_bit_strobe(stb), .dec_collision(coll), .mode_word(mode_word),
        .ctrl_word(ctrl_word), .station_address(sta), .multicast_hash_filter(hf),
        .hash_hit(hash_hit), .runt_accept(runt_accept), .rx_fifo_watermark(wm),
        .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data),
        .fifo_commit(fifo_commit), .fifo_discard(fifo_discard), .fifo_level(level),
        .status_valid(status_valid), .fcs_error_flag(fcs_err),
        .status_length(status_length), .buffer_manager_start(bms));
    always #20 mclk = ~mclk;
    always @(negedge mclk)
    begin
        rc <= rc + 2'h1;
        fifo_ready <= (rc != 2'h3);
    end
    always @(posedge mclk)
    begin
        if (fifo_valid === 1'b1 && fifo_ready === 1'b1)
            pushes++;
        if (fifo_commit === 1'b1)
            gc++;
        if (fifo_discard === 1'b1)
            gd++;
        if (status_valid === 1'b1)
        begin
            gs++;
            gl = status_length;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
        for (int k = 0; k < 8; k++)
            c = (c[0] ^ d[k]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
        return c;
    endfunction
    // ------------------------------------------------------------
    // frame build: fcs appended low byte first, optionally spoilt
    // ------------------------------------------------------------
    task automatic prep(input logic [47:0] d, input logic [15:0] lt, input int n, input int bad);
        logic [31:0] c;
        logic [7:0] v;
        c = 32'hffffffff;
        for (int i = 0; i < n + 4; i++)
        begin
            v = (i < 6) ? d[8*i+:8] : (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : i[7:0];
            if (i >= n)
                v = ~c[8*(i-n)+:8] ^ ((bad != 0 && i == n) ? 8'h01 : 8'h00);
            u_mrf_dec_model.fr[i] = v;
            if (i < n)
                c = crc_b(c, v);
        end
    endtask
    task automatic run(input logic [47:0] d, input logic [15:0] lt, input int n, input int cb,
        input int bad, input int ec, input int ed, input int ep);
        prep(d, lt, n, bad);
        pushes = 0;
        gc = 0;
        gd = 0;
        gs = 0;
        u_mrf_dec_model.send(n + 4, cb);
        repeat (40) @(negedge mclk);
        check("commit", gc, ec);
        check("discard", gd, ed);
        check("status", gs, ec);
        if (ep >= 0)
            check("pushes", pushes, ep);
        if (ec == 1 && ep >= 0)
            check("length", gl, ep);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_unicast;
        run(sta, 16'h0800, 60, -1, 0, 1, 0, 64);
        check("fcs ok", fcs_err, 0);
        run(sta ^ 48'h800000000000, 16'h0800, 60, -1, 0, 0, 1, 6);
        mode_word = 16'h2000;
        run(sta, 16'h0800, 60, -1, 0, 0, 1, 6);
    endtask
    task automatic t_bcast;
        mode_word = 16'h2000;
        run('1, 16'h0800, 60, -1, 0, 1, 0, 64);
        mode_word = 16'h4000;
        run('1, 16'h0800, 60, -1, 0, 0, 1, 6);
        mode_word = 16'he000;
        run('1, 16'h0800, 60, -1, 0, 1, 0, 64);
        run(sta ^ 48'h1000, 16'h0800, 60, -1, 0, 1, 0, 64);
    endtask
    task automatic t_mcast;
        mode_word = 16'h0000;
        hash_hit = 1'b1;
        run(48'h0000005e0001, 16'h0800, 60, -1, 0, 0, 1, 6);
        hf = 64'h0000000000000010;
        run(48'h0000005e0001, 16'h0800, 60, -1, 0, 1, 0, 64);
        hash_hit = 1'b0;
        run(48'h0000005e0001, 16'h0800, 60, -1, 0, 0, 1, 6);
    endtask
    task automatic t_runt;
        run(sta, 16'h0800, 56, -1, 0, 0, 1, -1);
        mode_word = 16'h8000;
        run(sta, 16'h0800, 56, -1, 0, 0, 1, -1);
        runt_accept = 1'b1;
        run(sta, 16'h0800, 56, -1, 0, 1, 0, 60);
        runt_accept = 1'b0;
        mode_word = 16'h0000;
    endtask
    task automatic t_strip_fcs;
        ctrl_word = 16'h0001;
        run(sta, 16'h000a, 60, -1, 0, 1, 0, 24);
        check("fcs pad", fcs_err, 0);
        run(sta, 16'h002e, 60, -1, 0, 1, 0, 64);
        ctrl_word = 16'h0000;
        run(sta, 16'h0800, 60, -1, 1, 1, 0, 64);
        check("fcs bad", fcs_err, 1);
        run(sta, 16'h0800, 60, 20, 0, 0, 1, -1);
    endtask
    task automatic t_queue;
        gc = 0;
        gd = 0;
        prep(sta, 16'h0800, 60, 0);
        u_mrf_dec_model.send(64, -1);
        prep(sta, 16'h0800, 56, 0);
        u_mrf_dec_model.send(60, -1);
        repeat (40) @(negedge mclk);
        check("queued commit", gc, 1);
        check("queued discard", gd, 1);
    endtask
    task automatic t_wm;
        logic [7:0] th [4] = '{8'h10, 8'h20, 8'h40, 8'h70};
        for (int w = 0; w < 4; w++)
        begin
            wm = w[1:0];
            level = th[w] - 8'h01;
            repeat (3) @(negedge mclk);
            check("wm below", bms, 0);
            level = th[w];
            repeat (3) @(negedge mclk);
            check("wm at", bms, 1);
        end
        level = 8'h00;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        // frames take ~3000 cycles each; nineteen frames fit comfortably
        #(40ns * 90000);
        num_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (2) @(negedge mclk);
        check("reset commit", fifo_commit, 0);
        check("reset start", bms, 0);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        t_unicast();
        t_bcast();
        t_mcast();
        t_runt();
        t_strip_fcs();
        t_queue();
        t_wm();
        print_verdict();
    end
endmodule
`default_nettype wire
